// [rtl/hco_params.svh]
// constants and behaviour notes for the host channel output port
`ifndef HCO_PARAMS_SVH
`define HCO_PARAMS_SVH
// Notes on behaviour
// RULE1: clear bits 2, 3, 4 reset address, data and readout logic.
// RULE2: address config sets strobe width, period and address word format.
// RULE3: software enables processor interrupt lines outside this block.
// RULE4: mask bits 6, 2, 1 gate done, single-bit, multi-bit flags.
// RULE5: software sets vector length to block length over four.
// RULE6: engine control write starts engine; no data before channel is ready.
// RULE7: writing host address word 0 starts sending address words.
// RULE8: flag 5 set after address phase; interrupt only when masked in.
// RULE9: data ready with valid data; host transmit data before next word.
// RULE10: block length drops by one per word sent.
// RULE11: output buffer is 128 entries used circularly.
// RULE12: engine fills buffer in four 32-word blocks, first block first.
// RULE13: engine stalls at a block not yet reserved.
// RULE14: entry address bits above 6 ignored, engine writes wrap.
// RULE15: readout works in eight 16-word blocks, advancing per block.
// RULE16: read a 16-word block only when full or holding final word.
// RULE17: read pointer wraps 127 to 0 and waits for block 0.
// RULE18: engine requests until vector length zero; done after all responses.
// RULE19: last word marker goes out with the final data word.
// RULE20: processor may fill buffer through its own address range.
// RULE21: software aborts engine with status select code two.
// RULE22: clear channel bit drives host clear; then clear bits 2 and 3.
// RULE23: readout parity mismatch sets error bit 8; clear bit 3 resets.
// RULE24: interrupt output high while any flag and its mask are set.
`define HCO_DW        32
`define HCO_IDX       7
`define HCO_OFF_CLR   12'h000
`define HCO_OFF_ACFG  12'h004
`define HCO_OFF_DCFG  12'h008
`define HCO_OFF_MASK  12'h00C
`define HCO_OFF_FLAG  12'h010
`define HCO_OFF_ERR   12'h014
`define HCO_OFF_BLLO  12'h018
`define HCO_OFF_BLHI  12'h01C
`define HCO_OFF_ADR0  12'h020
`define HCO_OFF_ADR1  12'h024
`define HCO_OFF_ECR   12'h028
`define HCO_OFF_ESR   12'h02C
`define HCO_OFF_EVL   12'h030
`define HCO_BUF_SEL   3'h2
`define HCO_CLR_ADDR  2
`define HCO_CLR_DATA  3
`define HCO_CLR_RDPTR 4
`define HCO_FLG_DONE  6
`define HCO_FLG_ADDR  5
`define HCO_FLG_SBE   2
`define HCO_FLG_MBE   1
`define HCO_FLG_IMPL  32'h0000_0066
`define HCO_ERR_PAR   8
`define HCO_ACFG_FMT  8
`define HCO_ACFG_CLR  12
`define HCO_ACFG_OK   13
`define HCO_ESR_ABORT 3'h2
`define HCO_OUT_BLK   8'h10
`define HCO_PKT_WORDS 8'h04
`define HCO_CLRCH_NS  150
`define HCO_CLK_MHZ   40
`define HCO_CLRCH_CYC ((`HCO_CLRCH_NS * `HCO_CLK_MHZ + 999) / 1000)
`endif

// [rtl/hco_pkg.sv]
// types shared by the host channel output port
`include "hco_params.svh"
package hco_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } hco_apb_req_t;

    typedef struct packed {
        logic [31:0]          addr;
        logic                 addr_ready;
        logic [`HCO_DW-1:0]   data;
        logic                 data_ready;
        logic                 last_word;
        logic                 clear_channel;
    } hco_host_out_t;

    typedef enum logic [1:0] {
        HCO_A_IDLE = 2'b01,
        HCO_A_SEND = 2'b10
    } hco_astate_t;

    typedef enum logic [2:0] {
        HCO_D_IDLE = 3'b001,
        HCO_D_WAIT = 3'b010,
        HCO_D_SEND = 3'b100
    } hco_dstate_t;
endpackage : hco_pkg

// [rtl/hco_top.sv]
// host channel output port: registers, buffer, engine fill, host send
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "hco_params.svh"
module hco_top #(
    parameter int VLW = 16
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire hco_pkg::hco_apb_req_t  apb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    output hco_pkg::hco_host_out_t      host,
    input  wire logic                   host_transmit_data,
    input  wire logic                   host_unrec_error,
    input  wire logic                   cpu_sbe,
    input  wire logic                   cpu_mbe,
    output logic                        gw_irq,
    output logic                        eng_req_valid,
    input  wire logic                   eng_req_ready,
    input  wire logic                   eng_resp_valid,
    input  wire logic [`HCO_DW-1:0]     eng_resp_data,
    output logic                        eng_resp_ready,
    output logic                        eng_irq
);
    localparam int DW = `HCO_DW;
    localparam int IX = `HCO_IDX;
    localparam logic [3:0] CC_CYC = 4'(`HCO_CLRCH_CYC);

    // ==========================================================
    // apb decode
    logic setup, acc, wr, buf_hit, mapped;
    logic clr_a, clr_d, clr_r;
    assign setup = apb.psel & ~apb.penable;
    assign acc   = apb.psel & apb.penable;
    assign wr    = acc & apb.pwrite;
    assign buf_hit = apb.paddr[11:9] == `HCO_BUF_SEL;
    assign pready  = 1'b1;

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = a == off;
    endfunction : hit

    assign mapped = buf_hit || apb.paddr <= `HCO_OFF_EVL
                    && apb.paddr[1:0] == 2'h0;
    assign clr_a = wr && hit(apb.paddr, `HCO_OFF_CLR)
                   && apb.pwdata[`HCO_CLR_ADDR]; // RULE1
    assign clr_d = wr && hit(apb.paddr, `HCO_OFF_CLR)
                   && apb.pwdata[`HCO_CLR_DATA]; // RULE1
    assign clr_r = wr && hit(apb.paddr, `HCO_OFF_CLR)
                   && apb.pwdata[`HCO_CLR_RDPTR]; // RULE1

    // ==========================================================
    // state declarations
    logic [31:0]        acfg_q, dcfg_q, mask_q, flags_q, bl_q;
    logic [31:0]        adr0_q, adr1_q, haddr_q, fl_set;
    logic [VLW-1:0]     evl_q, evc_q;
    logic [7:0]         wptr_q, rptr_q, outst_q, fill, bfill;
    logic [11:0]        la_q;
    logic [4:0]         acnt_q, ar_wid, ar_per, ar_last;
    logic [3:0]         cc_q;
    logic [DW:0]        mem_q [2**IX];
    logic [DW:0]        rd_word;
    logic [DW-1:0]      hdata_q, wdata;
    logic [IX-1:0]      widx;
    logic [2:0]         bdiff;
    logic               widx_q, dr_q, last_q, err_q, irq_q;
    logic               erun_q, edone_q, prd_err_q, clr_ok;
    logic               td_s1, td_s2, td_s3, ue_s1, ue_s2, td_rise;
    logic               addr_done, load, done_ev, par_ev, avail;
    logic               reserved, req_acc, resp_acc, cpu_we, mem_we;
    hco_pkg::hco_astate_t ast_q;
    hco_pkg::hco_dstate_t dst_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            td_s1 <= 1'b0;
            td_s2 <= 1'b0;
            td_s3 <= 1'b0;
            ue_s1 <= 1'b0;
            ue_s2 <= 1'b0;
        end else if (ce) begin
            td_s1 <= host_transmit_data;
            td_s2 <= td_s1;
            td_s3 <= td_s2;
            ue_s1 <= host_unrec_error;
            ue_s2 <= ue_s1;
        end
    end
    assign td_rise = td_s2 & ~td_s3;

    // ==========================================================
    // software registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acfg_q <= 32'h0;
            dcfg_q <= 32'h0;
            mask_q <= 32'h0;
            adr0_q <= 32'h0;
            adr1_q <= 32'h0;
            evl_q  <= '0;
        end else if (ce && wr) begin
            if (hit(apb.paddr, `HCO_OFF_ACFG))
                acfg_q <= apb.pwdata; // RULE2 RULE22
            if (hit(apb.paddr, `HCO_OFF_DCFG))
                dcfg_q <= apb.pwdata;
            if (hit(apb.paddr, `HCO_OFF_MASK))
                mask_q <= apb.pwdata & `HCO_FLG_IMPL;
            if (hit(apb.paddr, `HCO_OFF_ADR0))
                adr0_q <= apb.pwdata;
            if (hit(apb.paddr, `HCO_OFF_ADR1))
                adr1_q <= apb.pwdata;
            if (hit(apb.paddr, `HCO_OFF_EVL))
                evl_q <= apb.pwdata[VLW-1:0];
        end
    end

    // ==========================================================
    // flags and interrupt; a set in the clear cycle survives
    always_comb begin
        fl_set = 32'h0;
        fl_set[`HCO_FLG_DONE] = done_ev;
        fl_set[`HCO_FLG_ADDR] = addr_done; // RULE8
        fl_set[`HCO_FLG_SBE]  = cpu_sbe;
        fl_set[`HCO_FLG_MBE]  = cpu_mbe;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= 32'h0;
        end else if (ce) begin
            if (wr && hit(apb.paddr, `HCO_OFF_FLAG))
                flags_q <= (flags_q & ~apb.pwdata) | fl_set;
            else
                flags_q <= flags_q | fl_set;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            irq_q <= 1'b0;
        else if (ce)
            irq_q <= |(flags_q & mask_q); // RULE4 RULE8 RULE24
    end
    assign gw_irq = irq_q;

    property p_mask_gate;
        (cpu_sbe && mask_q[`HCO_FLG_SBE]) |-> ##2 gw_irq;
    endproperty
    a_mask_gate: assert property (p_mask_gate) // RULE4
        else $error("masked single-bit error did not raise irq");

    property p_no_unmasked;
        (flags_q & mask_q) == 32'h0 |=> !gw_irq;
    endproperty
    a_no_unmasked: assert property (p_no_unmasked) // RULE24
        else $error("irq raised with no enabled flag");

    // ==========================================================
    // address word sending
    assign ar_wid  = {1'b0, acfg_q[3:0]} + 5'h01;
    assign ar_per  = {1'b0, acfg_q[7:4]} + 5'h01;
    // always at least one low cycle between strobes
    assign ar_last = (ar_per > ar_wid) ? ar_per - 5'h01 : ar_wid;
    assign addr_done = ast_q == hco_pkg::HCO_A_SEND && acnt_q == ar_last
                       && (widx_q || acfg_q[`HCO_ACFG_FMT]) && !clr_a;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ast_q   <= hco_pkg::HCO_A_IDLE;
            acnt_q  <= 5'h0;
            widx_q  <= 1'b0;
            haddr_q <= 32'h0;
        end else if (ce) begin
            if (clr_a) begin
                ast_q  <= hco_pkg::HCO_A_IDLE; // RULE1
                acnt_q <= 5'h0;
                widx_q <= 1'b0;
            end else begin
                unique case (ast_q)
                    hco_pkg::HCO_A_IDLE: begin
                        if (wr && hit(apb.paddr, `HCO_OFF_ADR0)) begin
                            ast_q   <= hco_pkg::HCO_A_SEND; // RULE7
                            acnt_q  <= 5'h0;
                            widx_q  <= 1'b0;
                            haddr_q <= apb.pwdata;
                        end
                    end
                    hco_pkg::HCO_A_SEND: begin
                        if (acnt_q == ar_last) begin
                            acnt_q <= 5'h0;
                            // format bit: one combined word or two
                            if (widx_q || acfg_q[`HCO_ACFG_FMT]) begin
                                ast_q <= hco_pkg::HCO_A_IDLE; // RULE2
                            end else begin
                                widx_q  <= 1'b1;
                                haddr_q <= adr1_q;
                            end
                        end else begin
                            acnt_q <= acnt_q + 5'h01;
                        end
                    end
                endcase
            end
        end
    end

    sequence s_addr_start;
        ast_q == hco_pkg::HCO_A_SEND && acnt_q == 5'h0 && host.addr_ready;
    endsequence
    property p_addr_start;
        (wr && hit(apb.paddr, `HCO_OFF_ADR0) && !clr_a
         && ast_q == hco_pkg::HCO_A_IDLE) |=> s_addr_start;
    endproperty
    a_addr_start: assert property (p_addr_start) // RULE7
        else $error("address word 0 write did not start sending");

    property p_addr_flag;
        addr_done |=> flags_q[`HCO_FLG_ADDR];
    endproperty
    a_addr_flag: assert property (p_addr_flag) // RULE8
        else $error("address phase end did not set flag 5");

    // ==========================================================
    // circular buffer and pointers
    assign fill     = wptr_q - rptr_q;
    assign bfill    = wptr_q - {rptr_q[7:4], 4'h0};
    assign bdiff    = wptr_q[7:5] - rptr_q[7:5];
    assign reserved = ~bdiff[2]; // RULE12 RULE13
    assign avail    = fill != 8'h0 && (bfill >= `HCO_OUT_BLK
                      || {24'h0, fill} >= bl_q); // RULE15 RULE16
    assign load     = dst_q == hco_pkg::HCO_D_WAIT && avail
                      && bl_q != 32'h0 && !clr_d;
    assign resp_acc = eng_resp_valid & eng_resp_ready;
    // processor fills only while the engine is idle, keeping one writer
    assign cpu_we   = wr && buf_hit && !erun_q; // RULE20
    assign mem_we   = resp_acc | cpu_we;
    assign widx     = resp_acc ? la_q[IX-1:0] : apb.paddr[IX+1:2]; // RULE14
    assign wdata    = resp_acc ? eng_resp_data : apb.pwdata[DW-1:0];
    assign rd_word  = mem_q[rptr_q[IX-1:0]]; // RULE17
    assign par_ev   = load && (^rd_word[DW-1:0] != rd_word[DW]);

    always_ff @(posedge clk) begin
        if (ce && mem_we)
            mem_q[widx] <= {^wdata, wdata}; // RULE11
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr_q <= 8'h0;
            rptr_q <= 8'h0;
        end else if (ce) begin
            if (clr_d) begin
                wptr_q <= 8'h0;
                rptr_q <= 8'h0;
            end else begin
                if (mem_we)
                    wptr_q <= wptr_q + 8'h01;
                if (clr_r)
                    rptr_q <= 8'h0; // RULE1
                else if (load)
                    rptr_q <= rptr_q + 8'h01; // RULE17
            end
        end
    end

    property p_read_gate;
        load |-> bfill >= `HCO_OUT_BLK || {24'h0, fill} >= bl_q;
    endproperty
    a_read_gate: assert property (p_read_gate) // RULE16
        else $error("read from a block neither full nor final");

    // ==========================================================
    // host data send
    assign done_ev = dst_q == hco_pkg::HCO_D_SEND && td_rise
                     && last_q && !clr_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dst_q   <= hco_pkg::HCO_D_IDLE;
            dr_q    <= 1'b0;
            last_q  <= 1'b0;
            hdata_q <= '0;
        end else if (ce) begin
            if (clr_d) begin
                dst_q  <= hco_pkg::HCO_D_IDLE; // RULE1
                dr_q   <= 1'b0;
                last_q <= 1'b0;
            end else begin
                unique case (dst_q)
                    hco_pkg::HCO_D_IDLE: begin
                        if (addr_done)
                            dst_q <= hco_pkg::HCO_D_WAIT;
                    end
                    hco_pkg::HCO_D_WAIT: begin
                        if (load) begin
                            hdata_q <= rd_word[DW-1:0];
                            dr_q    <= 1'b1; // RULE9
                            last_q  <= bl_q == 32'h1; // RULE19
                            dst_q   <= hco_pkg::HCO_D_SEND;
                        end else if (bl_q == 32'h0) begin
                            dst_q <= hco_pkg::HCO_D_IDLE;
                        end
                    end
                    hco_pkg::HCO_D_SEND: begin
                        if (td_rise) begin
                            dr_q   <= 1'b0; // RULE9
                            last_q <= 1'b0;
                            dst_q  <= last_q ? hco_pkg::HCO_D_IDLE
                                             : hco_pkg::HCO_D_WAIT;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            bl_q <= 32'h0;
        else if (ce) begin
            if (wr && hit(apb.paddr, `HCO_OFF_BLLO))
                bl_q[15:0] <= apb.pwdata[15:0];
            else if (wr && hit(apb.paddr, `HCO_OFF_BLHI))
                bl_q[31:16] <= apb.pwdata[15:0];
            else if (load)
                bl_q <= bl_q - 32'h1; // RULE10
        end
    end

    // set beats clear, but load is blocked in the clear cycle, so no mismatch is seen then and the clear always wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            err_q <= 1'b0;
        else if (ce) begin
            if (par_ev)
                err_q <= 1'b1; // RULE23
            else if (clr_d)
                err_q <= 1'b0; // RULE23
        end
    end

    property p_hold_ready;
        (dr_q && !td_rise && !clr_d) |=> dr_q && $stable(hdata_q);
    endproperty
    a_hold_ready: assert property (p_hold_ready) // RULE9
        else $error("data ready dropped before transmit data");

    property p_bl_dec;
        load |=> bl_q == $past(bl_q) - 32'h1;
    endproperty
    a_bl_dec: assert property (p_bl_dec) // RULE10
        else $error("block length not decremented per word");

    property p_last;
        (load && bl_q == 32'h1) |=> host.last_word && host.data_ready
                                   && bl_q == 32'h0;
    endproperty
    a_last: assert property (p_last) // RULE19
        else $error("last word not marked with final data");

    property p_err_clr;
        (clr_d && !par_ev) |=> !err_q;
    endproperty
    a_err_clr: assert property (p_err_clr) // RULE23
        else $error("data clear did not reset parity error");

    // ==========================================================
    // transfer engine fill side
    assign eng_req_valid  = erun_q && dst_q != hco_pkg::HCO_D_IDLE
                            && evc_q != '0; // RULE6 RULE18
    assign req_acc        = eng_req_valid & eng_req_ready;
    assign eng_resp_ready = erun_q & reserved; // RULE13
    assign eng_irq        = edone_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            erun_q  <= 1'b0;
            edone_q <= 1'b0;
            evc_q   <= '0;
            outst_q <= 8'h0;
            la_q    <= 12'h0;
        end else if (ce) begin
            if (wr && hit(apb.paddr, `HCO_OFF_ECR)) begin
                erun_q  <= 1'b1; // RULE6
                edone_q <= 1'b0;
                evc_q   <= evl_q;
                outst_q <= 8'h0;
                la_q    <= 12'h0; // RULE12
            end else if (wr && hit(apb.paddr, `HCO_OFF_ESR)
                         && apb.pwdata[2:0] == `HCO_ESR_ABORT) begin
                erun_q <= 1'b0; // RULE21
            end else if (erun_q) begin
                if (req_acc)
                    evc_q <= evc_q - 1'b1;
                outst_q <= outst_q + (req_acc ? `HCO_PKT_WORDS : 8'h0)
                           - {7'h0, resp_acc};
                if (resp_acc)
                    la_q <= la_q + 12'h001; // RULE14
                if (evc_q == '0 && outst_q == 8'h0) begin
                    erun_q  <= 1'b0; // RULE18
                    edone_q <= 1'b1;
                end
            end
        end
    end

    property p_stall;
        !reserved |-> !eng_resp_ready;
    endproperty
    a_stall: assert property (p_stall) // RULE13
        else $error("engine accepted data into unreserved block");

    property p_done;
        $rose(eng_irq) |-> $past(outst_q) == 8'h0 && $past(evc_q) == '0;
    endproperty
    a_done: assert property (p_done) // RULE18
        else $error("engine done before all responses stored");

    // ==========================================================
    // clear channel hold time
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cc_q <= 4'h0;
        else if (ce) begin
            if (!acfg_q[`HCO_ACFG_CLR])
                cc_q <= 4'h0;
            else if (cc_q < CC_CYC)
                cc_q <= cc_q + 4'h1;
        end
    end
    assign clr_ok = acfg_q[`HCO_ACFG_CLR] && (cc_q >= CC_CYC || !ue_s2);

    // ==========================================================
    // apb read data captured in the setup cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata    <= 32'h0;
            prd_err_q <= 1'b0;
        end else if (ce && setup) begin
            prd_err_q <= !mapped;
            case (apb.paddr)
                `HCO_OFF_ACFG: begin
                    prdata <= acfg_q;
                    prdata[`HCO_ACFG_OK] <= clr_ok; // RULE22
                end
                `HCO_OFF_DCFG: prdata <= dcfg_q;
                `HCO_OFF_MASK: prdata <= mask_q;
                `HCO_OFF_FLAG: prdata <= flags_q;
                `HCO_OFF_ERR:  prdata <= {23'h0, err_q, 8'h0};
                `HCO_OFF_BLLO: prdata <= {16'h0, bl_q[15:0]};
                `HCO_OFF_BLHI: prdata <= {16'h0, bl_q[31:16]};
                `HCO_OFF_ADR0: prdata <= adr0_q;
                `HCO_OFF_ADR1: prdata <= adr1_q;
                `HCO_OFF_ESR:  prdata <= {30'h0, edone_q, erun_q};
                `HCO_OFF_EVL:  prdata <= 32'(evl_q);
                default:       prdata <= 32'h0;
            endcase
        end
    end
    assign pslverr = prd_err_q & acc;

    // ==========================================================
    // host pins
    assign host.addr          = haddr_q;
    assign host.addr_ready    = ast_q == hco_pkg::HCO_A_SEND
                                && acnt_q < ar_wid; // RULE2
    assign host.data          = hdata_q;
    assign host.data_ready    = dr_q;
    assign host.last_word     = last_q;
    assign host.clear_channel = acfg_q[`HCO_ACFG_CLR]; // RULE22
endmodule : hco_top

// [test/hco_partner.sv]
// far side model: host receiver and engine response source
`timescale 1ns/100ps
module hco_partner (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        data_ready,
    output logic             transmit_data,
    input  wire logic        req_valid,
    output logic             req_ready,
    output logic             resp_valid,
    output logic [31:0]      resp_data,
    input  wire logic        resp_ready
);
    logic [1:0]  td_q;
    logic [4:0]  owed_q;
    logic [31:0] word_q;
    // host acks each word two cycles late, drops two cycles after data ready
    assign transmit_data = td_q[1];
    assign resp_valid    = owed_q != 5'h0;
    // idle data bus never shows the last word
    assign resp_data     = resp_valid ? word_q : ~word_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            td_q      <= 2'h0;
            owed_q    <= 5'h0;
            word_q    <= 32'hA0000000;
            req_ready <= 1'b0;
        end else begin
            td_q      <= {td_q[0], data_ready};
            req_ready <= ~req_ready;
            owed_q    <= owed_q + ((req_valid && req_ready) ? 5'h4 : 5'h0)
                         - ((resp_valid && resp_ready) ? 5'h1 : 5'h0);
            if (resp_valid && resp_ready) word_q <= word_q + 32'h1;
        end
    end
endmodule : hco_partner

// [test/tb_host_channel_output_port.sv]
// self-checking bench for the host channel output port
`timescale 1ns/100ps
module tb_host_channel_output_port;
    logic                   clk = 0, rst = 1, sbe = 0, mbe = 0, dr_q = 0;
    logic                   td, pready, pslverr, gw_irq, eng_irq, err;
    logic                   qv, qr, rv, rr;
    logic [31:0]            prdata, rd, rdat, a0;
    hco_pkg::hco_apb_req_t  apb = '0;
    hco_pkg::hco_host_out_t host;
    int                     n_mismatch = 0, n_compared = 0, k = 0;
    always #12.5 clk = ~clk;
    hco_top i_dut (.clk(clk), .rst(rst), .ce(1'b1), .apb(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .host(host),
        .host_transmit_data(td), .host_unrec_error(1'b0), .cpu_sbe(sbe),
        .cpu_mbe(mbe), .gw_irq(gw_irq), .eng_req_valid(qv),
        .eng_req_ready(qr), .eng_resp_valid(rv), .eng_resp_data(rdat),
        .eng_resp_ready(rr), .eng_irq(eng_irq));
    hco_partner i_far (.clk(clk), .rst(rst), .data_ready(host.data_ready),
        .transmit_data(td), .req_valid(qv), .req_ready(qr),
        .resp_valid(rv), .resp_data(rdat), .resp_ready(rr));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic check(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        apb <= '0;
        @(posedge clk);
    endtask : bus
    always @(negedge clk) begin
        dr_q <= host.data_ready;
        if (host.data_ready === 1'b1 && dr_q === 1'b0) begin
            check("data", host.data, 32'hA0000000 + k);
            check("last", host.last_word, k == 15);
            k++;
        end
    end
    initial begin
        #500000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, 12'h010, 0);
        check("flags", rd, 0);
        bus(0, 12'h100, 0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        bus(1, 12'h00C, 32'h4);
        sbe <= 1'b1;
        @(posedge clk);
        sbe <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq_sbe", gw_irq, 1);
        bus(1, 12'h010, 32'h4);
        mbe <= 1'b1;
        @(posedge clk);
        mbe <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq_mbe", gw_irq, 0);
        bus(0, 12'h010, 0);
        check("flag_mbe", rd & 32'h66, 32'h2);
        bus(1, 12'h010, 32'h2);
        bus(1, 12'h004, 32'h11);
        bus(1, 12'h018, 32'h10);
        bus(1, 12'h01C, 32'h0);
        bus(1, 12'h030, 32'h4);
        bus(1, 12'h028, 32'h0);
        a0 = nxt(32'hF8E80FEE);
        bus(1, 12'h024, nxt(a0));
        bus(1, 12'h020, a0);
        for (int i = 0; i < 50 && host.addr_ready !== 1'b1; i++)
            @(negedge clk);
        check("addr0", host.addr, a0);
        repeat (3) @(negedge clk);
        check("addr1", host.addr, nxt(a0));
        for (int i = 0; i < 4000 && k < 16; i++) @(posedge clk);
        check("words", k, 16);
        // done flag only sets once the host acks the final word
        for (int i = 0; i < 50 && host.data_ready !== 1'b0; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        bus(0, 12'h010, 0);
        check("flags_done", rd & 32'h60, 32'h60);
        check("irq_unmasked", gw_irq, 0);
        bus(0, 12'h018, 0);
        check("length", rd & 32'hFFFF, 0);
        check("eng_done", eng_irq, 1);
        bus(1, 12'h028, 0);
        bus(1, 12'h02C, 32'h2);
        bus(0, 12'h02C, 0);
        check("abort", rd & 32'h3, 0);
        bus(1, 12'h004, 32'h1011);
        bus(0, 12'h004, 0);
        check("clr_chan", (rd & 32'h3000) | host.clear_channel,
              32'h3001);
        bus(1, 12'h000, 32'hC);
        bus(0, 12'h014, 0);
        check("parity_err", rd & 32'h100, 0);
        check("dr_cleared", host.data_ready, 0);
        summarize();
    end
endmodule : tb_host_channel_output_port
